// *** hdl/cie_irq_enable.sv ***
// Behaviour
// - bus wake-up event requests service only while enable bit 6 is one
// - error event requests service only while enable bit 5 is one
// - rx overflow event requests service only while enable bit 2 is one
// - rx buffer event requests service only while enable bit 1 is one
`timescale 1ns/1ps
`default_nettype none
module cie_irq_enable
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event flags from the controller, one bit per source
	input wire cie_pkg::cie_evt_t evt_flags,
	// gated request into the controller
	output logic can_irq_req,
	// summary interrupt from the sticky status
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	logic [15:0] enable_r, enable_nxt;
	logic [7:0] status_r, status_nxt;
	logic [7:0] mask_r, mask_nxt;
	logic [31:0] prdata_nxt;
	logic pready_r, pready_nxt, pslverr_nxt;
	logic req_r, req_nxt, irq_r, irq_nxt;
	logic [7:0] gated;
	logic setup, wr, rd, hit;

	// no wait state: answer in the first access cycle, the one after setup
	assign setup = psel && !penable;
	assign wr = psel && penable && pready_r && pwrite;
	assign rd = psel && penable && pready_r && !pwrite;

	// per-source gate; bit 4 has no source
	genvar g;
	generate
		for (g = 0; g < cie_pkg::EVT_W; g++)
		begin : gen_gate
			assign gated[g] = evt_flags[g] & enable_r[g] & cie_pkg::IMPL_MASK[g];
		end
	endgenerate

	always_comb
	begin
		hit = (paddr == cie_pkg::ENABLE_OFS) || (paddr == cie_pkg::STATUS_OFS) ||
			(paddr == cie_pkg::MASK_OFS);
		enable_nxt = enable_r;
		mask_nxt = mask_r;
		// set wins over the read clear
		status_nxt = status_r;
		// clear only what this read returned; an event landing during the access is kept
		if (rd && paddr == cie_pkg::STATUS_OFS)
			status_nxt = status_r & ~prdata[7:0];
		status_nxt = status_nxt | gated;
		if (wr && paddr == cie_pkg::ENABLE_OFS)
			enable_nxt = {8'h00, pwdata[7:0] & cie_pkg::IMPL_MASK};
		if (wr && paddr == cie_pkg::MASK_OFS)
			mask_nxt = pwdata[7:0] & cie_pkg::IMPL_MASK;
		pready_nxt = setup;
		pslverr_nxt = setup && !hit;
		prdata_nxt = 32'h0000_0000;
		if (setup && !pwrite)
		begin
			case (paddr)
				cie_pkg::ENABLE_OFS: prdata_nxt = {16'h0000, enable_r};
				cie_pkg::STATUS_OFS: prdata_nxt = {24'h00_0000, status_r};
				cie_pkg::MASK_OFS: prdata_nxt = {24'h00_0000, mask_r};
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
		req_nxt = |gated;
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_r <= cie_pkg::ENABLE_RST;
			status_r <= cie_pkg::STATUS_RST;
			mask_r <= cie_pkg::MASK_RST;
			prdata <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr <= 1'b0;
			req_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			enable_r <= enable_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			prdata <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr <= pslverr_nxt;
			req_r <= req_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign pready = pready_r;
	assign can_irq_req = req_r;
	assign irq = irq_r;

	////////////////////////////////////////////////////////////////////////
	property p_invalid_gate;
		@(posedge pclk) disable iff (!presetn)
		!enable_r[cie_pkg::INVALID_MSG_BIT] && evt_flags == 8'h80 |=> !can_irq_req;
	endproperty
	a_invalid_gate: assert property (p_invalid_gate) else $error("invalid msg leaked");

	property p_wake_pass;
		@(posedge pclk) disable iff (!presetn)
		enable_r[cie_pkg::WAKEUP_BIT] && evt_flags.wakeup |=> can_irq_req;
	endproperty
	a_wake_pass: assert property (p_wake_pass) else $error("wakeup not passed");

	property p_error_gate;
		@(posedge pclk) disable iff (!presetn)
		enable_r[cie_pkg::ERROR_BIT] != evt_flags.error && evt_flags == 8'h20 |=> !can_irq_req;
	endproperty
	a_error_gate: assert property (p_error_gate) else $error("error gate wrong");

	property p_ovf_pass;
		@(posedge pclk) disable iff (!presetn)
		enable_r[cie_pkg::RX_OVF_BIT] && evt_flags.rx_overflow |=> can_irq_req;
	endproperty
	a_ovf_pass: assert property (p_ovf_pass) else $error("overflow not passed");

	property p_rxbuf_pass;
		@(posedge pclk) disable iff (!presetn)
		enable_r[cie_pkg::RX_BUF_BIT] && evt_flags.rx_buffer |=> can_irq_req;
	endproperty
	a_rxbuf_pass: assert property (p_rxbuf_pass) else $error("rx buffer not passed");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |-> enable_r[15:8] == 8'h00 && !enable_r[cie_pkg::UNUSED_BIT];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	sequence s_en_write;
		psel && penable && pready && pwrite && paddr == cie_pkg::ENABLE_OFS;
	endsequence
	property p_en_write;
		@(posedge pclk) disable iff (!presetn)
		s_en_write |=> enable_r[7:0] == ($past(pwdata[7:0]) & cie_pkg::IMPL_MASK);
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable write lost");

	property p_txbuf_gate;
		@(posedge pclk) disable iff (!presetn)
		!enable_r[cie_pkg::TX_BUF_BIT] && evt_flags == 8'h01 |=> !can_irq_req;
	endproperty
	a_txbuf_gate: assert property (p_txbuf_gate) else $error("tx buffer leaked");

	property p_irq_status;
		@(posedge pclk) disable iff (!presetn)
		irq |-> (status_r & mask_r) != 8'h00;
	endproperty
	a_irq_status: assert property (p_irq_status) else $error("irq without status");

	property p_irq_level;
		@(posedge pclk) disable iff (!presetn)
		(status_r & mask_r) != 8'h00 |-> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq missing for masked status");

	property p_invalid_pass;
		@(posedge pclk) disable iff (!presetn)
		enable_r[cie_pkg::INVALID_MSG_BIT] && evt_flags.invalid_msg |=> can_irq_req;
	endproperty
	a_invalid_pass: assert property (p_invalid_pass) else $error("invalid msg not passed");

	property p_wake_gate;
		@(posedge pclk) disable iff (!presetn)
		!enable_r[cie_pkg::WAKEUP_BIT] && evt_flags == 8'h40 |=> !can_irq_req;
	endproperty
	a_wake_gate: assert property (p_wake_gate) else $error("wakeup leaked");

	property p_ovf_gate;
		@(posedge pclk) disable iff (!presetn)
		!enable_r[cie_pkg::RX_OVF_BIT] && evt_flags == 8'h04 |=> !can_irq_req;
	endproperty
	a_ovf_gate: assert property (p_ovf_gate) else $error("overflow leaked");

	property p_rxbuf_gate;
		@(posedge pclk) disable iff (!presetn)
		!enable_r[cie_pkg::RX_BUF_BIT] && evt_flags == 8'h02 |=> !can_irq_req;
	endproperty
	a_rxbuf_gate: assert property (p_rxbuf_gate) else $error("rx buffer leaked");

	property p_full_pass;
		@(posedge pclk) disable iff (!presetn)
		enable_r[cie_pkg::ALMOST_FULL_BIT] && evt_flags.almost_full |=> can_irq_req;
	endproperty
	a_full_pass: assert property (p_full_pass) else $error("almost full not passed");

	property p_txbuf_pass;
		@(posedge pclk) disable iff (!presetn)
		enable_r[cie_pkg::TX_BUF_BIT] && evt_flags.tx_buffer |=> can_irq_req;
	endproperty
	a_txbuf_pass: assert property (p_txbuf_pass) else $error("tx buffer not passed");

	sequence s_setup;
		psel && !penable;
	endsequence
	property p_answer;
		@(posedge pclk) disable iff (!presetn)
		s_setup |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer after setup");

	sequence s_bad_setup;
		psel && !penable && !hit;
	endsequence
	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		s_bad_setup |=> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

	sequence s_status_read;
		psel && penable && pready && !pwrite && paddr == cie_pkg::STATUS_OFS;
	endsequence
	property p_rd_clear;
		@(posedge pclk) disable iff (!presetn)
		s_status_read ##0 (evt_flags == 8'h00) |=> (status_r & $past(prdata[7:0])) == 8'h00;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("status not cleared by read");

	// a set in the same cycle as a read clear must survive
	property p_set_wins;
		@(posedge pclk) disable iff (!presetn)
		gated != 8'h00 |=> (status_r & $past(gated)) == $past(gated);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost from status");

endmodule
`default_nettype wire

// *** hdl/cie_pkg.sv ***
`default_nettype none
package cie_pkg;
	localparam int DATA_W = 32;
	localparam int EVT_W = 8;
	// register byte offsets
	localparam logic [7:0] ENABLE_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] MASK_OFS = 8'h08;
	// enable bit positions
	localparam int TX_BUF_BIT = 0;
	localparam int RX_BUF_BIT = 1;
	localparam int RX_OVF_BIT = 2;
	localparam int ALMOST_FULL_BIT = 3;
	localparam int UNUSED_BIT = 4;
	localparam int ERROR_BIT = 5;
	localparam int WAKEUP_BIT = 6;
	localparam int INVALID_MSG_BIT = 7;
	// writable bits: 7..5 and 3..0
	localparam logic [7:0] IMPL_MASK = 8'hEF;
	localparam logic [15:0] ENABLE_RST = 16'h0000;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;

	typedef struct packed {
		logic invalid_msg;
		logic wakeup;
		logic error;
		logic unused;
		logic almost_full;
		logic rx_overflow;
		logic rx_buffer;
		logic tx_buffer;
	} cie_evt_t;
endpackage
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, can_irq_req, irq;
	logic [7:0] paddr = 8'h00, en, ev, st = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	cie_pkg::cie_evt_t evt_flags = 8'h00;
	logic [32:0] exp_q[$];
	int errors = 0, n_compared = 0, seed = 32'h9c7d_696d;
	cie_irq_enable i_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.evt_flags(evt_flags), .can_irq_req(can_irq_req), .irq(irq));
	initial
	begin
		forever #25 pclk = ~pclk;
	end
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one full apb transfer; the extra edge keeps two transfers off one time step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic settle(input logic [7:0] e);
		evt_flags <= e;
		repeat (3) @(posedge pclk);
	endtask
	// read answers are paired with the oldest note, in issue order
	always @(posedge pclk)
	begin
		if (psel && penable && pready && !pwrite)
		begin
			if (exp_q.size() == 0)
				check("read note", 1'b1, 1'b0);
			else
				check("read", {pslverr, prdata}, exp_q.pop_front());
		end
	end
	initial
	begin
		#200_000;
		errors++;
		wrap_up();
	end
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		exp_q.push_back(33'h0_0000_0000);
		apb(1'b0, cie_pkg::ENABLE_OFS, 32'h0000_0000);
		apb(1'b1, cie_pkg::ENABLE_OFS, 32'hFFFF_FFFF);
		exp_q.push_back({25'h000_0000, cie_pkg::IMPL_MASK});
		apb(1'b0, cie_pkg::ENABLE_OFS, 32'h0000_0000);
		exp_q.push_back(33'h1_0000_0000);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		apb(1'b1, cie_pkg::MASK_OFS, 32'h0000_00FF);
		exp_q.push_back(33'h0_0000_0000);
		apb(1'b0, cie_pkg::STATUS_OFS, 32'h0000_0000);
		for (int i = 0; i < 8; i++)
		begin
			en = 8'h01 << i;
			// quiet the sources first so the new enable meets no stale event
			settle(8'h00);
			apb(1'b1, cie_pkg::ENABLE_OFS, {24'h00_0000, en});
			repeat (4)
			begin
				ev = 8'($random(seed));
				st = st | (ev & en & cie_pkg::IMPL_MASK);
				settle(ev);
				check("can_irq_req", can_irq_req, |(ev & en & cie_pkg::IMPL_MASK));
			end
		end
		settle(8'h00);
		check("irq", irq, |st);
		exp_q.push_back({25'h000_0000, st});
		apb(1'b0, cie_pkg::STATUS_OFS, 32'h0000_0000);
		check("irq", irq, 1'b0);
		apb(1'b1, cie_pkg::MASK_OFS, 32'h0000_0000);
		settle(8'h80);
		check("irq", irq, 1'b0);
		apb(1'b1, cie_pkg::MASK_OFS, 32'h0000_0080);
		check("irq", irq, 1'b1);
		exp_q.push_back({25'h000_0000, 8'h80});
		apb(1'b0, cie_pkg::MASK_OFS, 32'h0000_0000);
		// second reset in mid-run: enable and mask must come back cleared
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		exp_q.push_back(33'h0_0000_0000);
		apb(1'b0, cie_pkg::ENABLE_OFS, 32'h0000_0000);
		exp_q.push_back(33'h0_0000_0000);
		apb(1'b0, cie_pkg::MASK_OFS, 32'h0000_0000);
		check("can_irq_req", can_irq_req, 1'b0);
		check("irq", irq, 1'b0);
		check("notes left", exp_q.size(), 0);
		wrap_up();
	end
endmodule
`default_nettype wire
